// [logic/sfec_params.svh]
/*
 * Constants of the serial flash erase sequencer: frame lengths, status
 * bit positions, sector geometry, lock masks and erase timings.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef SFEC_PARAMS_SVH
`define SFEC_PARAMS_SVH

// ----------------------------------------------------------------------
// Instruction encodings (assumed encodings, overridable per instance)
// ----------------------------------------------------------------------
`define SFEC_OP_WRITE_ENABLE 8'h06
`define SFEC_OP_STATUS_READ 8'h05
`define SFEC_OP_SECTOR_ERASE 8'h52
`define SFEC_OP_CHIP_ERASE 8'h62

// ----------------------------------------------------------------------
// Frame and status layout
// ----------------------------------------------------------------------
`define SFEC_CMD_BITS 6'h08
`define SFEC_ADDR_FRAME_BITS 6'h20
`define SFEC_BIT_CNT_MAX 6'h3F
`define SFEC_STATUS_BUSY 0
`define SFEC_STATUS_WEL 1
`define SFEC_STATUS_BP_LOW 2
`define SFEC_STATUS_BP_HIGH 3

// ----------------------------------------------------------------------
// Array geometry: 32K byte sectors, 17 byte address bits kept
// ----------------------------------------------------------------------
`define SFEC_ARRAY_ADDR_BITS 17
`define SFEC_SECTOR_LSB 15
`define SFEC_SECTOR_FILL 18'h0_7FFF
`define SFEC_ERASED_BYTE 8'hFF
`define SFEC_SECTORS_LARGE 4'hF
`define SFEC_SECTORS_SMALL 4'h3

// ----------------------------------------------------------------------
// Locked sectors per protect level
// ----------------------------------------------------------------------
`define SFEC_LOCK_NONE 4'h0
`define SFEC_LOCK_TOP_QUARTER 4'h8
`define SFEC_LOCK_TOP_HALF 4'hC

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SFEC_MCLK_HZ 50000000.0
`define SFEC_CHIP_ERASE_S 3.5
`define SFEC_SECTOR_ERASE_S 1.0

`endif

// [logic/sfec_pkg.sv]
/*
 * Types of the serial flash erase sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package sfec_pkg;

    // Sequencer states
    typedef enum logic {
        SFEC_READY,
        SFEC_ERASING
    } sfec_state_t;

    typedef logic [3:0] sfec_sector_mask_t;

endpackage

`default_nettype wire

// [logic/sfec_erase_timer.sv]
/*
 * Down counter that times one self-timed erase cycle.
 * Assumes load is a one-cycle pulse on mclk; done stays high until
 * the next load.
 */
`default_nettype none

module sfec_erase_timer #(
    parameter int TIMER_W = 28
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Control
    input wire logic load,
    input wire logic [TIMER_W-1:0] load_value,
    // Result
    output logic done
);

    logic [TIMER_W-1:0] count;
    wire logic count_zero = (count == '0);

    always_ff @(posedge mclk) begin
        if (reset) begin
            count <= '0;
        end else if (load) begin
            count <= load_value;
        end else if (!count_zero) begin
            count <= count - 1'b1;
        end
    end

    // Registered so the sequencer sees a clean level
    always_ff @(posedge mclk) begin
        if (reset) begin
            done <= 1'b1;
        end else begin
            done <= count_zero && !load;
        end
    end

endmodule

`default_nettype wire

// [logic/sfec_top.sv]
/*
 * Serial flash erase sequencer: SPI front end, write enable latch,
 * sector and whole-array erase with block protection, status read.
 * Assumes SPI pins arrive asynchronously and are sampled by mclk,
 * which must run well above four times the serial clock; the array
 * itself sits outside and takes one byte write per mem_wr_en.
 */
// Behaviour
// - Sector erase needs write enable latch set
// - Sectors one and two are 32K each
// - Sectors three, four exist on large option only
// - Sector erase clears only unlocked sector
// - Any address inside sector selects it
// - Sector erase self-timed; only status read served
// - Sector erase end clears write enable
// - Array erase clears all unlocked sectors
// - Array erase needs write enable latch set
// - Array erase typically lasts 3.5 seconds
// - Array erase busy; only status read served
// - Array erase end clears write enable
// - Status bit zero shows cycle in progress
// - Protect bits choose locked sector set
// - High address bits ignored; bit 16 small zero
`include "sfec_params.svh"
`default_nettype none

module sfec_top #(
    parameter bit LARGE_ARRAY = 1'b1,
    parameter int TIMER_W = 28,
    parameter int unsigned CHIP_ERASE_CYCLES =
        int'(`SFEC_CHIP_ERASE_S * `SFEC_MCLK_HZ),
    parameter int unsigned SECTOR_ERASE_CYCLES =
        int'(`SFEC_SECTOR_ERASE_S * `SFEC_MCLK_HZ),
    parameter logic [7:0] OP_WRITE_ENABLE = `SFEC_OP_WRITE_ENABLE,
    parameter logic [7:0] OP_STATUS_READ = `SFEC_OP_STATUS_READ,
    parameter logic [7:0] OP_SECTOR_ERASE = `SFEC_OP_SECTOR_ERASE,
    parameter logic [7:0] OP_CHIP_ERASE = `SFEC_OP_CHIP_ERASE
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // SPI pins
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_si,
    output logic spi_so,
    output logic spi_so_oe,
    // Protection level
    input wire logic protect_level_bit_low,
    input wire logic protect_level_bit_high,
    // Array write port
    output logic mem_wr_en,
    output logic [`SFEC_ARRAY_ADDR_BITS-1:0] mem_wr_addr,
    output logic [7:0] mem_wr_data,
    // Status
    output logic busy,
    output logic write_enable_latch
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (TIMER_W < 2 || TIMER_W > 31 || CHIP_ERASE_CYCLES == 0 ||
        SECTOR_ERASE_CYCLES == 0 || CHIP_ERASE_CYCLES >= (64'd1 << TIMER_W)
        || SECTOR_ERASE_CYCLES >= (64'd1 << TIMER_W)) begin : g_bad_param
        $error("sfec_top: timer width or erase time unusable");
    end

    // ------------------------------------------------------------------
    // Lock decoding
    // ------------------------------------------------------------------
    function automatic sfec_pkg::sfec_sector_mask_t locked_sectors(
        input logic [1:0] level
    );
        sfec_pkg::sfec_sector_mask_t m;
        m = `SFEC_LOCK_NONE;
        if (level == 2'h3) begin
            m = LARGE_ARRAY ? `SFEC_SECTORS_LARGE : `SFEC_SECTORS_SMALL;
        end else if (LARGE_ARRAY && level == 2'h1) begin
            m = `SFEC_LOCK_TOP_QUARTER;
        end else if (LARGE_ARRAY && level == 2'h2) begin
            m = `SFEC_LOCK_TOP_HALF;
        end
        return m;
    endfunction

    function automatic sfec_pkg::sfec_sector_mask_t sector_onehot(
        input logic [1:0] idx
    );
        return sfec_pkg::sfec_sector_mask_t'(4'h1 << idx);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Third stage of cs and sclk only feeds edge detection
    logic [2:0] cs_sync;
    logic [2:0] sck_sync;
    logic [1:0] si_sync;

    always_ff @(posedge mclk) begin
        if (reset) begin
            cs_sync <= 3'h7;
            sck_sync <= 3'h0;
            si_sync <= 2'h0;
        end else begin
            cs_sync <= {cs_sync[1:0], spi_cs_n};
            sck_sync <= {sck_sync[1:0], spi_sclk};
            si_sync <= {si_sync[0], spi_si};
        end
    end

    wire logic selected = !cs_sync[1];
    wire logic sck_rise = selected && sck_sync[1] && !sck_sync[2];
    wire logic sck_fall = selected && !sck_sync[1] && sck_sync[2];
    wire logic cs_rise = cs_sync[1] && !cs_sync[2];

    // ------------------------------------------------------------------
    // Instruction shifter
    // ------------------------------------------------------------------
    logic [31:0] shift_in;
    logic [5:0] bit_cnt;
    logic status_mode;
    logic [2:0] out_cnt;
    logic [7:0] out_shift;

    wire logic [31:0] next_shift_in = {shift_in[30:0], si_sync[1]};
    wire logic count_full = (bit_cnt == `SFEC_BIT_CNT_MAX);
    wire logic opcode_done = (bit_cnt == `SFEC_CMD_BITS - 6'h01);

    always_ff @(posedge mclk) begin
        if (reset || !selected) begin
            shift_in <= '0;
            bit_cnt <= '0;
        end else if (sck_rise) begin
            shift_in <= next_shift_in;
            bit_cnt <= count_full ? bit_cnt : bit_cnt + 6'h01;
        end
    end

    // Served in every state, busy or not
    always_ff @(posedge mclk) begin
        if (reset || !selected) begin
            status_mode <= 1'b0;
        end else if (sck_rise && opcode_done &&
                     next_shift_in[7:0] == OP_STATUS_READ) begin
            status_mode <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Status output
    // ------------------------------------------------------------------
    logic [7:0] status_byte;
    always_comb begin
        status_byte = 8'h00;
        status_byte[`SFEC_STATUS_BUSY] = busy;
        status_byte[`SFEC_STATUS_WEL] = write_enable_latch;
        status_byte[`SFEC_STATUS_BP_LOW] = protect_level_bit_low;
        status_byte[`SFEC_STATUS_BP_HIGH] = protect_level_bit_high;
    end

    // Status is resampled per byte, so polling sees busy drop
    always_ff @(posedge mclk) begin
        if (reset || !status_mode) begin
            out_cnt <= '0;
            out_shift <= '0;
            spi_so <= 1'b0;
        end else if (sck_fall) begin
            out_cnt <= out_cnt + 3'h1;
            if (out_cnt == 3'h0) begin
                spi_so <= status_byte[7];
                out_shift <= {status_byte[6:0], 1'b0};
            end else begin
                spi_so <= out_shift[7];
                out_shift <= {out_shift[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            spi_so_oe <= 1'b0;
        end else begin
            spi_so_oe <= status_mode && selected;
        end
    end

    // ------------------------------------------------------------------
    // Frame decode at chip select release
    // ------------------------------------------------------------------
    sfec_pkg::sfec_state_t state;
    sfec_pkg::sfec_sector_mask_t erase_mask;
    sfec_pkg::sfec_sector_mask_t lock_at_start;
    logic [`SFEC_ARRAY_ADDR_BITS:0] walk;

    wire logic [1:0] protect_level =
        {protect_level_bit_high, protect_level_bit_low};
    wire sfec_pkg::sfec_sector_mask_t present =
        LARGE_ARRAY ? `SFEC_SECTORS_LARGE : `SFEC_SECTORS_SMALL;
    wire sfec_pkg::sfec_sector_mask_t unlocked =
        present & ~locked_sectors(protect_level);
    // Address bits above 16 never reach the sector index
    wire logic [1:0] sector_idx = shift_in[16:`SFEC_SECTOR_LSB];
    wire logic idle = (state == sfec_pkg::SFEC_READY);
    wire logic is_write_enable_command = cs_rise && bit_cnt == `SFEC_CMD_BITS &&
        shift_in[7:0] == OP_WRITE_ENABLE;
    wire logic is_sector = cs_rise && bit_cnt == `SFEC_ADDR_FRAME_BITS &&
        shift_in[31:24] == OP_SECTOR_ERASE;
    wire logic is_chip = cs_rise && bit_cnt == `SFEC_CMD_BITS &&
        shift_in[7:0] == OP_CHIP_ERASE;
    // Without write enable the frame is simply dropped
    wire logic start_erase = idle && write_enable_latch &&
        (is_sector || is_chip);
    wire sfec_pkg::sfec_sector_mask_t next_mask = is_chip ? unlocked :
        unlocked & sector_onehot(sector_idx);
    // Small option with bit 16 set: busy cycle, nothing cleared
    wire logic [TIMER_W-1:0] erase_time = is_chip ?
        TIMER_W'(CHIP_ERASE_CYCLES) : TIMER_W'(SECTOR_ERASE_CYCLES);

    // ------------------------------------------------------------------
    // Erase timing and array walk
    // ------------------------------------------------------------------
    logic timer_done;
    sfec_erase_timer #(.TIMER_W(TIMER_W)) u_timer (
        .mclk(mclk),
        .reset(reset),
        .load(start_erase),
        .load_value(erase_time),
        .done(timer_done)
    );

    wire logic walk_done = walk[`SFEC_ARRAY_ADDR_BITS];
    wire logic [`SFEC_ARRAY_ADDR_BITS-1:0] walk_addr =
        walk[`SFEC_ARRAY_ADDR_BITS-1:0];
    wire logic walk_hit = !idle && !walk_done &&
        erase_mask[walk_addr[16:`SFEC_SECTOR_LSB]];
    wire logic [`SFEC_ARRAY_ADDR_BITS:0] next_walk = walk_hit ?
        walk + 1'b1 : (walk | `SFEC_SECTOR_FILL) + 1'b1;
    // Cycle ends only when both the time and the walk are over
    wire logic finish = !idle && timer_done && walk_done;

    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= sfec_pkg::SFEC_READY;
            erase_mask <= '0;
            lock_at_start <= '0;
            walk <= '0;
        end else if (start_erase) begin
            state <= sfec_pkg::SFEC_ERASING;
            erase_mask <= next_mask;
            lock_at_start <= locked_sectors(protect_level);
            walk <= '0;
        end else if (finish) begin
            state <= sfec_pkg::SFEC_READY;
        end else if (!idle && !walk_done) begin
            walk <= next_walk;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mem_wr_en <= 1'b0;
            mem_wr_addr <= '0;
            mem_wr_data <= `SFEC_ERASED_BYTE;
        end else begin
            mem_wr_en <= walk_hit;
            mem_wr_addr <= walk_addr;
            mem_wr_data <= `SFEC_ERASED_BYTE;
        end
    end

    // ------------------------------------------------------------------
    // Write enable latch and busy
    // ------------------------------------------------------------------
    // Set only when idle, clear only at cycle end: never together
    always_ff @(posedge mclk) begin
        if (reset) begin
            write_enable_latch <= 1'b0;
        end else if (finish) begin
            write_enable_latch <= 1'b0;
        end else if (is_write_enable_command && idle) begin
            write_enable_latch <= 1'b1;
        end
    end

    assign busy = !idle;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    a_start_needs_wel: assert property (
        $rose(busy) |-> $past(write_enable_latch) && $past(cs_rise))
        else $error("erase started without write enable");

    a_end_clears_wel: assert property (
        $fell(busy) |-> !write_enable_latch)
        else $error("write enable survived erase end");

    a_busy_ignores_write_enable_command: assert property (
        busy && !finish |=> !$rose(write_enable_latch))
        else $error("write enable set during erase");

    a_locked_untouched: assert property (
        mem_wr_en |-> !lock_at_start[mem_wr_addr[16:`SFEC_SECTOR_LSB]])
        else $error("locked sector written");

    a_small_no_upper: assert property (
        mem_wr_en |-> LARGE_ARRAY || !mem_wr_addr[16])
        else $error("absent sector written on small option");

    a_sector_onehot: assert property (
        $rose(busy) && $past(is_sector) |-> $onehot0(erase_mask))
        else $error("sector erase selects several sectors");

    a_erased_all_ones: assert property (
        mem_wr_en |-> mem_wr_data == `SFEC_ERASED_BYTE)
        else $error("erase writes other than all ones");

    a_status_busy_bit: assert property (
        status_byte[`SFEC_STATUS_BUSY] == (state != sfec_pkg::SFEC_READY))
        else $error("status busy bit wrong");

    a_busy_held_walk: assert property (
        $rose(busy) |-> busy [*8])
        else $error("erase cycle ended too early");

    a_start_on_cs_rise: assert property (
        $rose(busy) |-> $past(cs_sync[1]) && !$past(cs_sync[2]))
        else $error("erase began without chip select release");

endmodule

`default_nettype wire

// [verification/sfec_host_model.sv]
/*
 * Host side SPI controller model for the flash erase sequencer.
 * Assumes mode 0 framing at 160 ns per serial clock; mclk of 20 ns.
 */
`default_nettype none

module sfec_host_model (
    // Clock
    input wire logic mclk,
    // SPI pins
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_si,
    input wire logic spi_so,
    input wire logic spi_so_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------------
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_si = 1'b0;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // ------------------------------------------------------------------
    // One frame, MSB first; bits after the eighth are read back
    // ------------------------------------------------------------------
    // Low phase of 5 cycles, high of 3: the slave's output is settled
    // before the rise, where it is sampled.
    task automatic xfer(input int nbits, input logic [31:0] tx,
                        output logic [7:0] rx);
        int i;
        rx = 8'h00;
        @(posedge mclk);
        spi_cs_n <= 1'b0;
        for (i = 0; i < nbits; i++) begin
            spi_si <= tx[nbits-1-i];
            ticks(5);
            // Undriven line reads as the inverse of its last level
            if (i >= 8) begin
                rx = {rx[6:0], spi_so_oe ? spi_so : ~spi_so};
            end
            spi_sclk <= 1'b1;
            ticks(3);
            spi_sclk <= 1'b0;
        end
        ticks(4);
        spi_cs_n <= 1'b1;
        // Released data line must not keep showing the last bit
        spi_si <= ~spi_si;
        ticks(6);
    endtask

endmodule

`default_nettype wire

// [verification/test_serial_flash_erase_control.sv]
/*
 * Self-checking bench of the flash erase sequencer: frames from the
 * host model, array writes watched at the write port.
 * Assumes erase timers shortened to 200 cycles; the array walk, one
 * cycle per cleared byte, sets the run length.
 */
`include "sfec_params.svh"
`default_nettype none

module test_serial_flash_erase_control;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk;
    logic reset;
    logic spi_cs_n;
    logic spi_sclk;
    logic spi_si;
    logic spi_so;
    logic spi_so_oe;
    logic protect_level_bit_low;
    logic protect_level_bit_high;
    logic mem_wr_en;
    logic [16:0] mem_wr_addr;
    logic [7:0] mem_wr_data;
    logic busy;
    logic write_enable_latch;
    logic [16:0] win_lo;
    logic [16:0] win_hi;
    logic [16:0] last_addr;
    logic [7:0] st;
    int n_errors;
    int cmp_count;
    int wr_count;
    int cycles;

    // ------------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------------
    sfec_top #(
        .LARGE_ARRAY(1'b1),
        .CHIP_ERASE_CYCLES(200),
        .SECTOR_ERASE_CYCLES(200)
    ) u_dut (
        .mclk(mclk),
        .reset(reset),
        .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk),
        .spi_si(spi_si),
        .spi_so(spi_so),
        .spi_so_oe(spi_so_oe),
        .protect_level_bit_low(protect_level_bit_low),
        .protect_level_bit_high(protect_level_bit_high),
        .mem_wr_en(mem_wr_en),
        .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data),
        .busy(busy),
        .write_enable_latch(write_enable_latch)
    );

    sfec_host_model u_host (
        .mclk(mclk),
        .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk),
        .spi_si(spi_si),
        .spi_so(spi_so),
        .spi_so_oe(spi_so_oe)
    );

    always #10 mclk = ~mclk;

    // ------------------------------------------------------------------
    // Compare tasks and verdict
    // ------------------------------------------------------------------
    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_byte(input string what, input logic [7:0] exp,
                            input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_count(input string what, input int exp,
                             input int got);
        cmp_count++;
        if (got != exp) begin
            n_errors++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic test_done;
        $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Array write watcher: writes only inside the open window
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 120000) begin
            n_errors++;
            $display("ERROR timeout waiting for the erase sequence");
            test_done();
        end
        if (mem_wr_en === 1'b1) begin
            chk_bit("write inside window", 1'b1,
                    mem_wr_addr >= win_lo && mem_wr_addr <= win_hi);
            chk_byte("cleared byte", 8'hFF, mem_wr_data);
            if (wr_count > 0) begin
                chk_bit("ascending", 1'b1, mem_wr_addr > last_addr);
            end
            last_addr = mem_wr_addr;
            wr_count++;
        end
    end

    // ------------------------------------------------------------------
    // Frame helpers
    // ------------------------------------------------------------------
    task automatic status(output logic [7:0] s);
        u_host.xfer(16, {16'h0000, `SFEC_OP_STATUS_READ, 8'h00}, s);
    endtask

    task automatic cmd(input logic [7:0] op);
        logic [7:0] d;
        u_host.xfer(8, {24'h00_0000, op}, d);
    endtask

    task automatic sec_erase(input logic [23:0] addr);
        logic [7:0] d;
        u_host.xfer(32, {`SFEC_OP_SECTOR_ERASE, addr}, d);
    endtask

    // Polls the busy bit; enough polls to outlast one array walk
    task automatic wait_idle(output logic [7:0] s);
        int n;
        n = 0;
        s = 8'h01;
        while (s[0] !== 1'b0 && n < 600) begin
            status(s);
            n++;
        end
        repeat (20) @(posedge mclk);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        protect_level_bit_low = 1'b0;
        protect_level_bit_high = 1'b0;
        n_errors = 0;
        cmp_count = 0;
        wr_count = 0;
        cycles = 0;
        last_addr = 17'h0_0000;
        win_lo = 17'h1_FFFF;
        win_hi = 17'h0_0000;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        chk_bit("busy after reset", 1'b0, busy);
        chk_bit("wel after reset", 1'b0, write_enable_latch);
        chk_bit("so_oe after reset", 1'b0, spi_so_oe);
        status(st);
        chk_byte("status level 0", 8'h00, st);
        sec_erase(24'h00_1234);
        chk_bit("busy sector erase no wel", 1'b0, busy);
        cmd(`SFEC_OP_CHIP_ERASE);
        chk_bit("busy chip erase no wel", 1'b0, busy);
        protect_level_bit_low <= 1'b1;
        @(posedge mclk);
        cmd(`SFEC_OP_WRITE_ENABLE);
        chk_bit("wel set", 1'b1, write_enable_latch);
        status(st);
        chk_byte("status wel level 1", 8'h06, st);
        // Sector three via an inner address with don't-care bits set
        win_lo = 17'h1_0000;
        win_hi = 17'h1_7FFF;
        wr_count = 0;
        sec_erase(24'hFF_2A3C);
        chk_bit("busy sector erase", 1'b1, busy);
        status(st);
        chk_byte("status sector erasing", 8'h07, st);
        cmd(`SFEC_OP_WRITE_ENABLE);
        cmd(`SFEC_OP_CHIP_ERASE);
        wait_idle(st);
        chk_bit("busy after sector erase", 1'b0, busy);
        chk_bit("wel after sector erase", 1'b0, write_enable_latch);
        chk_byte("status after sector erase", 8'h04, st);
        chk_count("sector bytes cleared", 32768, wr_count);
        // Level 2 locks sectors three and four
        protect_level_bit_low <= 1'b0;
        protect_level_bit_high <= 1'b1;
        @(posedge mclk);
        cmd(`SFEC_OP_WRITE_ENABLE);
        win_lo = 17'h0_0000;
        win_hi = 17'h0_FFFF;
        wr_count = 0;
        cmd(`SFEC_OP_CHIP_ERASE);
        chk_bit("busy chip erase", 1'b1, busy);
        sec_erase(24'h00_0100);
        status(st);
        chk_byte("status chip erasing", 8'h0B, st);
        wait_idle(st);
        chk_bit("busy after chip erase", 1'b0, busy);
        chk_bit("wel after chip erase", 1'b0, write_enable_latch);
        chk_byte("status after chip erase", 8'h08, st);
        chk_count("array bytes cleared", 65536, wr_count);
        test_done();
    end

endmodule

`default_nettype wire
